// file: core/usb_ctl_pkg.sv
// Shared constants and types for the USB control, address and frame registers.
// Assumes a 100 MHz module clock and a plain byte-addressed register port.
package usb_ctl_pkg;
	// Register byte addresses.
	localparam logic [7:0] ADDR_CONTROL     = 8'h00;
	localparam logic [7:0] ADDR_DEV_ADDRESS = 8'h04;
	localparam logic [7:0] ADDR_FRAME_LOW   = 8'h08;
	localparam logic [7:0] ADDR_FRAME_HIGH  = 8'h0C;
	// Control bit positions.
	localparam int BIT_ENABLE   = 0;
	localparam int BIT_PPRESET  = 1;
	localparam int BIT_RESUME   = 2;
	localparam int BIT_HOST     = 3;
	localparam int BIT_BUSY     = 5;
	// Address register field positions.
	localparam int BIT_LOWSPEED = 7;
	localparam int ADDR_W       = 7;
	// Frame number split.
	localparam int FRAME_W      = 11;
	localparam int FRAME_LOW_W  = 8;
	localparam int FRAME_HIGH_W = 3;
	// Reset values.
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	// Timing: SOF interval and clock period.
	localparam int CLK_PERIOD_NS  = 10;
	localparam int SOF_PERIOD_US  = 1000;
	localparam int SOF_CYCLES     = (SOF_PERIOD_US * 1000) / CLK_PERIOD_NS;
	// Length of the low-speed end-of-packet after resume, in cycles.
	localparam int EOP_CYCLES     = 4;
	// Register port request carried as one bundle.
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;
endpackage : usb_ctl_pkg

// file: core/sof_timer.sv
// Start-of-frame interval timer for the host role.
// Assumes the caller clears it through clr whenever host logic is reset.
`timescale 1ns/100ps
`default_nettype none
module sof_timer
	import usb_ctl_pkg::*;
#(
	parameter int PERIOD = SOF_CYCLES
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic run,
	input  wire logic clr,
	output logic      tick
);
	// Cycle counter within the current frame.
	logic [$clog2(PERIOD)-1:0] cnt_q;

	// Counts while running and pulses tick once per period.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			tick  <= 1'b0;
		end else if (clr || !run) begin
			// Stopped timers restart a full period later.
			cnt_q <= '0;
			tick  <= 1'b0;
		end else if (cnt_q == ($clog2(PERIOD))'(PERIOD - 1)) begin
			cnt_q <= '0;
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1'b1;
			tick  <= 1'b0;
		end
	end
endmodule // sof_timer
`default_nettype wire

// file: core/usb_ctl_regs.sv
// Control, address and frame-number registers of a dual-role USB controller.
// Assumes the packet engine reports tokens, SOF reception and the frame number.
`timescale 1ns/100ps
`default_nettype none
module usb_ctl_regs
	import usb_ctl_pkg::*;
#(
	parameter int SOF_PERIOD = SOF_CYCLES
) (
	input  wire logic               clk,
	input  wire logic               nrst,
	input  wire logic [7:0]         addr,
	input  wire logic [31:0]        wdata,
	input  wire logic               wr,
	input  wire logic               rd,
	output logic [31:0]             rdata,
	input  wire logic               token_start,
	input  wire logic               token_done,
	input  wire logic               sof_received,
	input  wire logic [FRAME_W-1:0] frame_in,
	output logic                    module_enable,
	output logic                    frame_start_enable,
	output logic                    host_role_enable,
	output logic                    resume_active,
	output logic                    pingpong_pointer_reset,
	output logic                    host_logic_reset,
	output logic                    sof_send,
	output logic                    lowspeed_eop,
	output logic                    low_speed_select,
	output logic [ADDR_W-1:0]       device_address_field
);
	// Reset synchroniser stages.
	logic rst_meta_q;
	logic rst_n;
	// Stored control bits.
	logic en_q;
	logic resume_q;
	logic host_q;
	logic busy_q;
	// Address register fields.
	logic              ls_q;
	logic [ADDR_W-1:0] dev_q;
	// Latched frame number.
	logic [FRAME_W-1:0] frame_q;
	// Low-speed EOP cycle counter.
	logic [$clog2(EOP_CYCLES+1)-1:0] eop_cnt_q;
	// Request bundle and decoded write strobes.
	reg_req_t req;
	logic     wr_ctl;
	logic     wr_adr;
	logic     sof_tick;
	logic     host_toggle;

	// Returns true when a write hits the given address.
	function automatic logic hit(input reg_req_t r, input logic [7:0] a);
		return r.wr && (r.addr == a);
	endfunction

	// Bundles the port signals and decodes writes.
	always_comb begin
		req.addr    = addr;
		req.wdata   = wdata;
		req.wr      = wr;
		req.rd      = rd;
		wr_ctl      = hit(req, ADDR_CONTROL);
		wr_adr      = hit(req, ADDR_DEV_ADDRESS);
		host_toggle = wr_ctl && (wdata[BIT_HOST] != host_q);
	end

	// Releases the asynchronous reset through two flip-flops.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			// Shift a one through both stages before the release.
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// Control register storage.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// All control bits are clear after reset.
			en_q     <= 1'b0;
			resume_q <= 1'b0;
			host_q   <= 1'b0;
		end else if (wr_ctl) begin
			en_q     <= wdata[BIT_ENABLE];
			// Resume level follows software; its timing is up to software.
			resume_q <= wdata[BIT_RESUME];
			host_q   <= wdata[BIT_HOST];
		end
	end

	// Ping-pong reset and host reset pulses.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// No pulses leave the block during reset.
			pingpong_pointer_reset <= 1'b0;
			host_logic_reset       <= 1'b0;
		end else begin
			// one-cycle pointer reset on a written one.
			pingpong_pointer_reset <= wr_ctl && wdata[BIT_PPRESET];
			// any toggle of host enable resets host logic.
			host_logic_reset       <= host_toggle;
		end
	end

	// Token busy flag, set wins over token done; a host toggle clear wins over set.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// No token is in progress after reset.
			busy_q <= 1'b0;
		end else if (host_toggle) begin
			// host reset drops an active token.
			busy_q <= 1'b0;
		end else if (host_q && token_start) begin
			busy_q <= 1'b1;
		end else if (token_done) begin
			// The engine has finished the token.
			busy_q <= 1'b0;
		end
	end

	// Address register storage.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// Address zero at full speed after reset.
			ls_q  <= 1'b0;
			dev_q <= '0;
		end else if (wr_adr) begin
			ls_q  <= wdata[BIT_LOWSPEED];
			dev_q <= wdata[ADDR_W-1:0];
		end
	end

	// Frame number latch; register writes never reach it.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// Frame number reads zero until the first SOF.
			frame_q <= '0;
		end else if (sof_received) begin
			frame_q <= frame_in;
		end
	end

	// SOF interval timer.
	sof_timer #(
		.PERIOD (SOF_PERIOD)
	) u_sof (
		.clk   (clk),
		.rst_n (rst_n),
		.run   (host_q && en_q),
		.clr   (host_toggle),
		.tick  (sof_tick)
	);

	// Low-speed EOP after resume is cleared in host role.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// No EOP is pending after reset.
			eop_cnt_q <= '0;
		end else if (host_toggle) begin
			eop_cnt_q <= '0;
		end else if (wr_ctl && resume_q && !wdata[BIT_RESUME] && host_q) begin
			eop_cnt_q <= ($bits(eop_cnt_q))'(EOP_CYCLES);
		end else if (eop_cnt_q != '0) begin
			// One more EOP cycle has elapsed.
			eop_cnt_q <= eop_cnt_q - 1'b1;
		end
	end

	// Registered role outputs.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// All role outputs stay low during reset.
			module_enable        <= 1'b0;
			frame_start_enable   <= 1'b0;
			host_role_enable     <= 1'b0;
			resume_active        <= 1'b0;
			sof_send             <= 1'b0;
			lowspeed_eop         <= 1'b0;
			low_speed_select     <= 1'b0;
			device_address_field <= '0;
		end else begin
			// bit 0 is module enable in device role.
			module_enable        <= en_q && !host_q;
			// bit 0 is SOF enable in host role.
			frame_start_enable   <= en_q && host_q;
			host_role_enable     <= host_q;
			resume_active        <= resume_q;
			sof_send             <= sof_tick && host_q && en_q;
			lowspeed_eop         <= eop_cnt_q != '0;
			low_speed_select     <= ls_q;
			device_address_field <= dev_q;
		end
	end

	// Read data, valid the cycle after the read strobe.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// Read data idle at zero during reset.
			rdata <= RESET_WORD;
		end else begin
			// Unselected bits and idle cycles read zero.
			rdata <= RESET_WORD;
			if (req.rd) begin
				case (req.addr)
					ADDR_CONTROL: begin
						rdata[BIT_ENABLE] <= en_q;
						rdata[BIT_RESUME] <= resume_q;
						rdata[BIT_HOST]   <= host_q;
						rdata[BIT_BUSY]   <= busy_q && host_q;
					end
					ADDR_DEV_ADDRESS: begin
						rdata[BIT_LOWSPEED]  <= ls_q;
						rdata[ADDR_W-1:0]    <= dev_q;
					end
					ADDR_FRAME_LOW: begin
						rdata[FRAME_LOW_W-1:0] <= frame_q[FRAME_LOW_W-1:0];
					end
					ADDR_FRAME_HIGH: begin
						// frame bits 10-8; upper bits zero.
						rdata[FRAME_HIGH_W-1:0] <= frame_q[FRAME_W-1:FRAME_LOW_W];
					end
					default: begin
						// Unmapped addresses read zero.
						rdata <= RESET_WORD;
					end
				endcase
			end
		end
	end

	// Ping-pong reset follows a written one by one cycle.
	ppreset_a: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_ctl && wdata[BIT_PPRESET]) |=> pingpong_pointer_reset)
		else $error("pointer reset missing");
	// Module enable tracks bit 0 outside host role.
	modenable_a: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_ctl && !wdata[BIT_HOST]) |=> ##1 (module_enable == $past(wdata[BIT_ENABLE], 2)))
		else $error("module enable wrong");
	// No SOF without host role and enable.
	sofgate_a: assert property (@(posedge clk) disable iff (!rst_n)
		sof_send |-> $past(host_q && en_q))
		else $error("SOF sent while disabled");
	// Host toggle pulses the host reset.
	hostrst_a: assert property (@(posedge clk) disable iff (!rst_n)
		host_toggle |=> (host_logic_reset && !busy_q))
		else $error("host reset missing");
	// Resume clear in host starts EOP.
	eopstart_a: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_ctl && resume_q && !wdata[BIT_RESUME] && host_q) |=> ##1 lowspeed_eop[*4])
		else $error("low-speed EOP wrong");
	// Address write appears on outputs two cycles later.
	addrout_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr_adr |=> ##1 (device_address_field == $past(wdata[ADDR_W-1:0], 2)
			&& low_speed_select == $past(wdata[BIT_LOWSPEED], 2)))
		else $error("address output wrong");
	// Frame latches on SOF only.
	framehold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!$past(sof_received) |-> $stable(frame_q))
		else $error("frame changed without SOF");
	// Frame high read keeps upper bits zero.
	framehigh_a: assert property (@(posedge clk) disable iff (!rst_n)
		(rd && addr == ADDR_FRAME_HIGH) |=> (rdata[31:FRAME_HIGH_W] == '0))
		else $error("frame high upper bits set");
	// Busy set by token start in host role.
	busyset_a: assert property (@(posedge clk) disable iff (!rst_n)
		(host_q && token_start && !host_toggle) |=> busy_q)
		else $error("busy not set");

	// A written zero on the pointer reset bit gives no pulse.
	ppkeep_a: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_ctl && !wdata[BIT_PPRESET]) |=> !pingpong_pointer_reset)
		else $error("pointer reset without request");
	// Host enable reaches its output two cycles after the write.
	hostout_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr_ctl |=> ##1 (host_role_enable == $past(wdata[BIT_HOST], 2)))
		else $error("host enable output wrong");
	// The SOF timer stays silent unless host role and enable are both set.
	sofstop_a: assert property (@(posedge clk) disable iff (!rst_n)
		!(host_q && en_q) |=> !sof_tick)
		else $error("SOF timer ticked while stopped");
	// A host enable toggle also aborts a running EOP.
	eopabort_a: assert property (@(posedge clk) disable iff (!rst_n)
		host_toggle |=> (eop_cnt_q == '0))
		else $error("EOP survived host reset");
	// Token completion clears busy unless a new token starts.
	busyclr_a: assert property (@(posedge clk) disable iff (!rst_n)
		(token_done && !token_start && !host_toggle) |=> !busy_q)
		else $error("busy not cleared");
	// SOF reception latches the frame number presented with it.
	framelatch_a: assert property (@(posedge clk) disable iff (!rst_n)
		sof_received |=> (frame_q == $past(frame_in)))
		else $error("frame number not latched");
	// Frame low read returns the low frame bits and zero above them.
	framelow_a: assert property (@(posedge clk) disable iff (!rst_n)
		(rd && addr == ADDR_FRAME_LOW) |=> (rdata[31:FRAME_LOW_W] == '0
			&& rdata[FRAME_LOW_W-1:0] == $past(frame_q[FRAME_LOW_W-1:0])))
		else $error("frame low read wrong");
	// Frame high read returns the three upper frame bits.
	framehighval_a: assert property (@(posedge clk) disable iff (!rst_n)
		(rd && addr == ADDR_FRAME_HIGH) |=>
			(rdata[FRAME_HIGH_W-1:0] == $past(frame_q[FRAME_W-1:FRAME_LOW_W])))
		else $error("frame high read wrong");
	// Address read returns the stored device address.
	devread_a: assert property (@(posedge clk) disable iff (!rst_n)
		(rd && addr == ADDR_DEV_ADDRESS) |=> (rdata[ADDR_W-1:0] == $past(dev_q)))
		else $error("device address read wrong");

	sofseen_c: cover property (@(posedge clk) disable iff (!rst_n) sof_send);
	eopseen_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(lowspeed_eop));
	framelatch_c: cover property (@(posedge clk) disable iff (!rst_n) sof_received);
	hostflip_c: cover property (@(posedge clk) disable iff (!rst_n) host_logic_reset);
	busydone_c: cover property (@(posedge clk) disable iff (!rst_n) $fell(busy_q));
endmodule // usb_ctl_regs
`default_nettype wire

// file: verif/usb_engine_model.sv
// Packet engine stand-in that feeds token and SOF events to the register block.
// Assumes the bench asks for events by one-cycle pulses on clk.
`timescale 1ns/100ps
`default_nettype none
module usb_engine_model
	import usb_ctl_pkg::*;
#(
	parameter int TOK_LEN = 6
) (
	input  wire logic               clk,
	input  wire logic               sof_req,
	input  wire logic [FRAME_W-1:0] sof_frame,
	input  wire logic               tok_req,
	output logic                    token_start,
	output logic                    token_done,
	output logic                    sof_received,
	output logic [FRAME_W-1:0]      frame_in
);
	int cnt; // Cycles left in the running token.

	// Everything starts idle.
	initial begin
		cnt = 0;
		token_start = 1'b0;
		token_done = 1'b0;
		sof_received = 1'b0;
		frame_in = '0;
	end

	// The frame number is valid only beside its SOF pulse; it toggles otherwise.
	always @(posedge clk) begin
		sof_received <= sof_req;
		frame_in     <= sof_req ? sof_frame : ~frame_in;
		token_start  <= tok_req;
		token_done   <= (cnt == 1);
		if (tok_req) begin
			cnt <= TOK_LEN;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
	end
endmodule // usb_engine_model
`default_nettype wire

// file: verif/usb_ctl_regs_tb_top.sv
// Self-checking bench for the USB control, address and frame registers.
// Assumes the engine model in its own file and a 100 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module usb_ctl_regs_tb_top;
	import usb_ctl_pkg::*;
	localparam int SOFP = 50; // Shortened SOF interval.
	logic               clk, nrst;
	reg_req_t           req;
	logic [31:0]        rdata;
	logic               t_st, t_dn, sof_rx, sof_req, tok_req;
	logic [FRAME_W-1:0] f_in, sof_frame;
	logic               m_en, fs_en, h_en, res, ppr, hlr, sof, eop, lss;
	logic [ADDR_W-1:0]  dev;
	int                 fail_count = 0;
	int                 total_checks = 0;

	usb_ctl_regs #(.SOF_PERIOD(SOFP)) dut (.clk(clk), .nrst(nrst), .addr(req.addr),
		.wdata(req.wdata), .wr(req.wr), .rd(req.rd), .rdata(rdata), .token_start(t_st),
		.token_done(t_dn), .sof_received(sof_rx), .frame_in(f_in), .module_enable(m_en),
		.frame_start_enable(fs_en), .host_role_enable(h_en), .resume_active(res),
		.pingpong_pointer_reset(ppr), .host_logic_reset(hlr), .sof_send(sof),
		.lowspeed_eop(eop), .low_speed_select(lss), .device_address_field(dev));
	usb_engine_model peer (.clk(clk), .sof_req(sof_req), .sof_frame(sof_frame),
		.tok_req(tok_req), .token_start(t_st), .token_done(t_dn), .sof_received(sof_rx),
		.frame_in(f_in));

	// Free-running clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk);
		req.rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd_reg(a, d);
		chk(d, exp);
	endtask

	function automatic logic pick(input int s);
		case (s)
			0: return ppr;
			1: return hlr;
			2: return sof;
			default: return eop;
		endcase
	endfunction

	// Counts the cycles in which one output is high over a window.
	task automatic count_hi(input int s, input int win, input int exp);
		int n;
		n = 0;
		repeat (win) begin
			#1 n += int'(pick(s) === 1'b1);
			@(posedge clk);
		end
		chk(n, exp);
	endtask

	// Measures the spacing between two SOF pulses.
	task automatic sof_gap;
		int n;
		n = 0;
		while (sof !== 1'b1 && n < 3 * SOFP) begin
			@(posedge clk);
			#1 n++;
		end
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (sof !== 1'b1 && n < 3 * SOFP);
		chk(n, SOFP);
	endtask

	task automatic t_reset;
		for (int a = 0; a < 5; a++) rd_chk(8'(a * 4), 32'h0000_0000);
		$display("reset test done");
	endtask

	task automatic t_addr;
		logic [31:0] v [2] = '{32'hABCD_EF55, 32'h0000_00AA};
		foreach (v[i]) begin
			wr_reg(ADDR_DEV_ADDRESS, v[i]);
			repeat (2) @(posedge clk);
			#1 chk({lss, dev}, v[i][7:0]);
			rd_chk(ADDR_DEV_ADDRESS, {24'h0, v[i][7:0]});
		end
		$display("address test done");
	endtask

	task automatic t_frame;
		logic [10:0] f [2] = '{11'h5A3, 11'h7FF};
		foreach (f[i]) begin
			@(posedge clk);
			sof_req <= 1'b1;
			sof_frame <= f[i];
			@(posedge clk);
			sof_req <= 1'b0;
			repeat (3) @(posedge clk);
			rd_chk(ADDR_FRAME_LOW, {24'h0, f[i][7:0]});
			rd_chk(ADDR_FRAME_HIGH, {29'h0, f[i][10:8]});
		end
		wr_reg(ADDR_FRAME_LOW, 32'h0000_0000);
		wr_reg(ADDR_FRAME_HIGH, 32'hFFFF_FFF8);
		rd_chk(ADDR_FRAME_LOW, 32'h0000_00FF);
		rd_chk(ADDR_FRAME_HIGH, 32'h0000_0007);
		$display("frame test done");
	endtask

	task automatic t_device;
		wr_reg(ADDR_CONTROL, 32'h1);
		repeat (3) @(posedge clk);
		#1 chk({m_en, fs_en}, 2'b10);
		wr_reg(ADDR_CONTROL, 32'h3);
		count_hi(0, 4, 1);
		wr_reg(ADDR_CONTROL, 32'h1);
		count_hi(0, 4, 0);
		wr_reg(ADDR_CONTROL, 32'h5);
		wr_reg(ADDR_CONTROL, 32'h1);
		count_hi(3, 10, 0);
		rd_chk(ADDR_CONTROL, 32'h1);
		$display("device test done");
	endtask

	task automatic t_host;
		logic [31:0] d;
		int n;
		wr_reg(ADDR_CONTROL, 32'h9);
		count_hi(1, 4, 1);
		#1 chk({m_en, fs_en, h_en}, 3'b011);
		sof_gap();
		@(posedge clk);
		tok_req <= 1'b1;
		@(posedge clk);
		tok_req <= 1'b0;
		rd_chk(ADDR_CONTROL, 32'h29);
		n = 0;
		do begin
			rd_reg(ADDR_CONTROL, d);
			n++;
		end while (d[BIT_BUSY] !== 1'b0 && n < 20);
		chk(d, 32'h9);
		wr_reg(ADDR_CONTROL, 32'hD);
		repeat (20) @(posedge clk);
		#1 chk(res, 1'b1);
		wr_reg(ADDR_CONTROL, 32'h9);
		count_hi(3, 10, EOP_CYCLES);
		wr_reg(ADDR_CONTROL, 32'h8);
		count_hi(1, 4, 0);
		count_hi(2, 2 * SOFP, 0);
		wr_reg(ADDR_CONTROL, 32'h0);
		count_hi(1, 4, 1);
		count_hi(2, 2 * SOFP, 0);
		$display("host test done");
	endtask

	task automatic results;
		$display("checks=%0d mismatches=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Watchdog against a hang.
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		results();
	end

	// Main sequence.
	initial begin
		nrst = 1'b0;
		req = '0;
		sof_req = 1'b0;
		tok_req = 1'b0;
		sof_frame = '0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_addr();
		t_frame();
		t_device();
		t_host();
		results();
	end
endmodule // usb_ctl_regs_tb_top
`default_nettype wire
